// File: logic/llcf_ctrl.sv
/*
 Digital control for the feedback chain and current protection of a
 resonant half-bridge controller. Takes comparator outputs, drives the
 analog selectors, ramp direction and fault reporting.
 Assumes all inputs are already synchronous to clock.
*/
// Notes on behaviour
// RULE_01: Gate supply below lockout in normal running moves system to fault.
// RULE_02: Feedback copy below burst threshold stops half-bridge switching.
// RULE_03: Feedback-below-burst for over 200 ms returns to startup and retries.
// RULE_04: Switching never starts while feedback-below-burst flag is true.
// RULE_05: Pick-lower second input is soft-start level, or analog supply once done.
// RULE_06: Soft-start done needs ramp above feedback, soft start begun, no capacitive event.
// RULE_07: Capacitive-region event clears soft-start done.
// RULE_08: Charge enable is enable and not done and not capacitive.
// RULE_09: Pick-higher passes higher of pick-lower output and burst threshold choice.
// RULE_10: Burst threshold mux selects ground during soft start, threshold after.
// RULE_11: Pick-higher comparator gives feedback-below-burst flag for burst and shutdown.
// RULE_12: Resonant sense compared to upper, lower and common levels, all delivered.
// RULE_13: Resonant sense shorted to common level while idle or before startup.
// RULE_14: Compensation ramp always on, reverses at each side's on falling edge.
// RULE_15: Current direction edges in the first 400 ns of dead time ignored.
// RULE_16: Average-current mux passes differentiated signal only while high side on.
// RULE_17: Average faults need comparator high continuously 2 ms and 50 ms.
// RULE_18: Peak current checked once per cycle during positive half cycle.
// RULE_19: Peak fault needs events in 4 consecutive cycles.
// RULE_20: Peak comparator ignored for first 15 switching cycles of startup.
// RULE_21: High side off above upper threshold, low side off below lower threshold.
// RULE_22: Duration timers restart from zero when their condition goes false.
// RULE_23: Peak cycle counter clears on any evaluated cycle without an event.
module llcf_ctrl import llcf_pkg::*; #(
   parameter int unsigned FB_LOW_LIMIT = FB_LOW_CYC,
   parameter int unsigned AVG_HIGH_LIMIT = AVG_HIGH_CYC,
   parameter int unsigned AVG_LOW_LIMIT = AVG_LOW_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // System requests
   input wire logic start_request,
   input wire logic gate_supply_low,
   input wire logic softstart_enable,
   // Feedback chain comparators
   input wire logic softstart_above_feedback,
   input wire logic feedback_below_burst_cmp,
   input wire logic capacitive_region,
   // Resonant sense comparators
   input wire logic sense_above_upper,
   input wire logic sense_below_lower,
   input wire logic sense_above_common,
   // Gate timing from the waveform generator
   input wire logic high_side_on,
   input wire logic low_side_on,
   // Current sensing comparators
   input wire logic current_direction_flag,
   input wire logic high_average_cmp,
   input wire logic low_average_cmp,
   input wire logic peak_overcurrent_cmp,
   // Analog steering
   output logic softstart_done_q,
   output logic softstart_charge_enable_q,
   output logic select_supply_q,
   output logic select_burst_threshold_q,
   output logic sense_short_q,
   output logic ramp_up_q,
   output logic average_mux_pass_q,
   // To waveform generator
   output logic switching_allowed_q,
   output logic feedback_below_burst_flag_q,
   output logic sense_above_upper_q,
   output logic sense_below_lower_q,
   output logic sense_above_common_q,
   output logic high_side_stop_q,
   output logic low_side_stop_q,
   output logic current_direction_q,
   // Status
   output logic [4:0] system_state_q,
   output logic gate_supply_fault_q,
   output logic peak_overcurrent_q,
   output logic high_average_overcurrent_q,
   output logic low_average_overcurrent_q
);
   llcf_state_e state_q, state_d;
   logic hs_prev_q, ls_prev_q;
   logic [4:0] blank_q;
   logic [3:0] start_cyc_q;
   logic [2:0] peak_run_q;
   logic peak_seen_q;
   logic fb_long_low, avg_hi_exp, avg_lo_exp;
   logic hs_fall, ls_fall, hs_rise, any_fault;

   // Sixteen counts of blanking need a five-bit counter
   localparam logic [4:0] BLANK_LIM = 5'(BLANK_CYC);
   localparam logic [3:0] START_LIM = 4'(START_IGNORE);
   localparam logic [2:0] PEAK_LIM = 3'(PEAK_RUN);

   function automatic logic falling(input logic prev, input logic now);
      falling = prev & ~now;
   endfunction

   assign hs_fall = falling(hs_prev_q, high_side_on);
   assign ls_fall = falling(ls_prev_q, low_side_on);
   assign hs_rise = falling(high_side_on, hs_prev_q);
   assign any_fault = peak_overcurrent_q | high_average_overcurrent_q | low_average_overcurrent_q;

   // ------------------------------------------------------------
   // Duration qualifiers
   // ------------------------------------------------------------
   llcf_timer #(.LIMIT(FB_LOW_LIMIT)) u_fb_low ( // RULE_03
      .clock(clock),
      .reset(reset),
      .cond(feedback_below_burst_cmp),
      .expired_q(fb_long_low)
   );
   llcf_timer #(.LIMIT(AVG_HIGH_LIMIT)) u_avg_hi ( // RULE_17
      .clock(clock),
      .reset(reset),
      .cond(high_average_cmp),
      .expired_q(avg_hi_exp)
   );
   llcf_timer #(.LIMIT(AVG_LOW_LIMIT)) u_avg_lo ( // RULE_17
      .clock(clock),
      .reset(reset),
      .cond(low_average_cmp),
      .expired_q(avg_lo_exp)
   );

   // ------------------------------------------------------------
   // System state
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         LLCF_IDLE: begin
            if (start_request) begin
               state_d = LLCF_START;
            end
         end
         LLCF_START: begin
            // A feedback pin held low keeps the system parked here
            if (!feedback_below_burst_cmp && softstart_enable) begin
               state_d = LLCF_SOFT; // RULE_04
            end
         end
         LLCF_SOFT: begin
            if (gate_supply_low || any_fault) begin
               state_d = LLCF_FAULT; // RULE_01
            end else if (softstart_done_q) begin
               state_d = LLCF_RUN;
            end
         end
         LLCF_RUN: begin
            if (gate_supply_low || any_fault) begin
               state_d = LLCF_FAULT; // RULE_01
            end else if (fb_long_low) begin
               state_d = LLCF_START; // RULE_03
            end
         end
         LLCF_FAULT: begin
            if (!start_request) begin
               state_d = LLCF_IDLE;
            end
         end
         default: state_d = LLCF_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= LLCF_IDLE;
         system_state_q <= 5'h01;
         gate_supply_fault_q <= 1'b0;
      end else begin
         state_q <= state_d;
         system_state_q <= state_d;
         if (state_q == LLCF_IDLE && start_request) begin
            gate_supply_fault_q <= 1'b0;
         end else if ((state_q == LLCF_RUN || state_q == LLCF_SOFT) && gate_supply_low) begin
            gate_supply_fault_q <= 1'b1; // RULE_01
         end
      end
   end

   // ------------------------------------------------------------
   // Soft start and selectors
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         softstart_done_q <= 1'b0;
         softstart_charge_enable_q <= 1'b0;
         select_supply_q <= 1'b0;
         select_burst_threshold_q <= 1'b0;
      end else begin
         // Capacitive event forces done low so a pulled-down ramp wins the pick-lower
         softstart_done_q <= softstart_above_feedback && softstart_enable
                             && !capacitive_region; // RULE_06 RULE_07
         softstart_charge_enable_q <= softstart_enable && !softstart_done_q
                                      && !capacitive_region; // RULE_08
         select_supply_q <= softstart_done_q; // RULE_05
         select_burst_threshold_q <= (state_q == LLCF_RUN); // RULE_10 RULE_09
      end
   end

   // ------------------------------------------------------------
   // Switching permission and comparator delivery
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         switching_allowed_q <= 1'b0;
         feedback_below_burst_flag_q <= 1'b0;
         sense_above_upper_q <= 1'b0;
         sense_below_lower_q <= 1'b0;
         sense_above_common_q <= 1'b0;
         high_side_stop_q <= 1'b0;
         low_side_stop_q <= 1'b0;
         sense_short_q <= 1'b1;
      end else begin
         switching_allowed_q <= (state_d == LLCF_SOFT || state_d == LLCF_RUN)
                                && !feedback_below_burst_cmp; // RULE_02
         feedback_below_burst_flag_q <= feedback_below_burst_cmp; // RULE_11
         sense_above_upper_q <= sense_above_upper; // RULE_12
         sense_below_lower_q <= sense_below_lower;
         sense_above_common_q <= sense_above_common;
         high_side_stop_q <= sense_above_upper; // RULE_21
         low_side_stop_q <= sense_below_lower; // RULE_21
         // Shorting settles the sense node, cutting the first-pulse peak current
         sense_short_q <= !(state_d == LLCF_SOFT || state_d == LLCF_RUN)
                          || feedback_below_burst_cmp; // RULE_13
      end
   end

   // ------------------------------------------------------------
   // Compensation ramp and average mux
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         hs_prev_q <= 1'b0;
         ls_prev_q <= 1'b0;
         ramp_up_q <= 1'b0;
         average_mux_pass_q <= 1'b0;
      end else begin
         hs_prev_q <= high_side_on;
         ls_prev_q <= low_side_on;
         if (hs_fall || ls_fall) begin
            ramp_up_q <= ~ramp_up_q; // RULE_14
         end
         average_mux_pass_q <= high_side_on; // RULE_16
      end
   end

   // ------------------------------------------------------------
   // Current direction blanking
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         blank_q <= 5'h00;
         current_direction_q <= 1'b0;
      end else begin
         if (hs_fall || ls_fall) begin
            blank_q <= BLANK_LIM;
         end else if (blank_q != 5'h00) begin
            blank_q <= blank_q - 5'h01;
         end
         // Held value during blanking hides ringing at the switched node
         if (blank_q == 5'h00 && !hs_fall && !ls_fall) begin
            current_direction_q <= current_direction_flag; // RULE_15
         end
      end
   end

   // ------------------------------------------------------------
   // Peak overcurrent
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         start_cyc_q <= 4'h0;
         peak_seen_q <= 1'b0;
         peak_run_q <= 3'h0;
         peak_overcurrent_q <= 1'b0;
      end else begin
         if (state_q == LLCF_START || state_q == LLCF_IDLE) begin
            start_cyc_q <= 4'h0;
         end else if (hs_fall && start_cyc_q != START_LIM) begin
            start_cyc_q <= start_cyc_q + 4'h1;
         end
         // Sample within the positive half cycle only
         // An event on the first high-side cycle belongs to the new half cycle, so set wins
         if (high_side_on && peak_overcurrent_cmp) begin
            peak_seen_q <= 1'b1; // RULE_18
         end else if (hs_rise) begin
            peak_seen_q <= 1'b0;
         end
         if (state_q == LLCF_IDLE) begin
            peak_run_q <= 3'h0;
            peak_overcurrent_q <= 1'b0;
         end else if (hs_fall && start_cyc_q == START_LIM) begin // RULE_20
            if (!peak_seen_q) begin
               peak_run_q <= 3'h0; // RULE_23
            end else if (peak_run_q != PEAK_LIM) begin
               peak_run_q <= peak_run_q + 3'h1;
               if (peak_run_q == PEAK_LIM - 3'h1) begin
                  peak_overcurrent_q <= 1'b1; // RULE_19
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Average overcurrent faults, sticky until idle
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         high_average_overcurrent_q <= 1'b0;
         low_average_overcurrent_q <= 1'b0;
      end else begin
         if (avg_hi_exp) begin
            high_average_overcurrent_q <= 1'b1; // RULE_17
         end else if (state_q == LLCF_IDLE) begin
            high_average_overcurrent_q <= 1'b0;
         end
         if (avg_lo_exp) begin
            low_average_overcurrent_q <= 1'b1; // RULE_17
         end else if (state_q == LLCF_IDLE) begin
            low_average_overcurrent_q <= 1'b0;
         end
      end
   end
endmodule

// File: logic/llcf_pkg.sv
/*
 Package for the resonant feedback and current protection control block.
 Holds state encodings, timing figures and derived cycle counts.
 Assumes a single 40 MHz clock.
*/
package llcf_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned FB_LOW_MS = 200;
   localparam int unsigned AVG_HIGH_MS = 2;
   localparam int unsigned AVG_LOW_MS = 50;
   localparam int unsigned BLANK_NS = 400;
   // Least times round up
   localparam int unsigned FB_LOW_CYC = FB_LOW_MS * (CLK_HZ / 1000);
   localparam int unsigned AVG_HIGH_CYC = AVG_HIGH_MS * (CLK_HZ / 1000);
   localparam int unsigned AVG_LOW_CYC = AVG_LOW_MS * (CLK_HZ / 1000);
   localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam int unsigned PEAK_RUN = 4;
   localparam int unsigned START_IGNORE = 15;
   localparam int unsigned TMR_W = 24;
   localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
   // ------------------------------------------------------------
   // System states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      LLCF_IDLE  = 5'b00001,
      LLCF_START = 5'b00010,
      LLCF_SOFT  = 5'b00100,
      LLCF_RUN   = 5'b01000,
      LLCF_FAULT = 5'b10000
   } llcf_state_e;
endpackage

// File: logic/llcf_timer.sv
/*
 Continuous-duration qualifier: the output rises once the condition has
 held for LIMIT cycles, and the count restarts whenever it drops.
 Assumes the condition is synchronous to clock.
*/
module llcf_timer import llcf_pkg::*; #(
   parameter int unsigned LIMIT = 80000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Condition and result
   input wire logic cond,
   output logic expired_q
);
   localparam logic [TMR_W-1:0] LIM = TMR_W'(LIMIT - 1);
   logic [TMR_W-1:0] count_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_q <= TMR_ZERO;
      end else if (!cond) begin
         count_q <= TMR_ZERO; // RULE_22
      end else if (count_q != LIM) begin
         count_q <= count_q + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         expired_q <= 1'b0;
      end else begin
         expired_q <= cond && (count_q == LIM);
      end
   end
endmodule

// File: testbench/llcf_ctrl_properties.sv
/*
 Port checker for llcf_ctrl, bound to every instance of it.
 Assumes one clock domain and outputs registered one cycle after their inputs.
*/
module llcf_ctrl_properties import llcf_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Watched inputs
   input wire logic softstart_enable,
   input wire logic softstart_above_feedback,
   input wire logic capacitive_region,
   input wire logic feedback_below_burst_cmp,
   input wire logic gate_supply_low,
   input wire logic sense_above_upper,
   input wire logic sense_below_lower,
   input wire logic sense_above_common,
   input wire logic high_side_on,
   input wire logic low_side_on,
   // Watched outputs
   input wire logic softstart_done_q,
   input wire logic softstart_charge_enable_q,
   input wire logic select_burst_threshold_q,
   input wire logic sense_short_q,
   input wire logic ramp_up_q,
   input wire logic average_mux_pass_q,
   input wire logic switching_allowed_q,
   input wire logic feedback_below_burst_flag_q,
   input wire logic sense_above_upper_q,
   input wire logic sense_below_lower_q,
   input wire logic sense_above_common_q,
   input wire logic high_side_stop_q,
   input wire logic low_side_stop_q,
   input wire logic current_direction_q,
   input wire logic [4:0] system_state_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // Steps
   // ------------------------------------------------------------
   sequence s_gate_fall;
      !$past(reset) && ($fell(high_side_on) || $fell(low_side_on));
   endsequence
   sequence s_dir_frozen;
      $stable(current_direction_q) [*8] ##1 $stable(current_direction_q) [*6];
   endsequence
   property p_done;
      !$past(reset) |-> softstart_done_q == $past(softstart_above_feedback && softstart_enable && !capacitive_region);
   endproperty
   property p_charge;
      !$past(reset) |-> softstart_charge_enable_q == $past(softstart_enable && !softstart_done_q && !capacitive_region);
   endproperty
   property p_burst_sel;
      system_state_q == LLCF_SOFT |-> !select_burst_threshold_q;
   endproperty
   property p_ramp;
      s_gate_fall |-> ##[1:2] (ramp_up_q != $past(ramp_up_q));
   endproperty
   // Blanking is checked a little short of its full span to stay clear of the release edge
   property p_blank;
      s_gate_fall |=> s_dir_frozen;
   endproperty
   property p_mux;
      !$past(reset) |-> average_mux_pass_q == $past(high_side_on);
   endproperty
   property p_stops;
      !$past(reset) |-> high_side_stop_q == $past(sense_above_upper) && low_side_stop_q == $past(sense_below_lower);
   endproperty
   property p_copies;
      !$past(reset) |-> {sense_above_upper_q, sense_below_lower_q, sense_above_common_q, feedback_below_burst_flag_q}
         == $past({sense_above_upper, sense_below_lower, sense_above_common, feedback_below_burst_cmp});
   endproperty
   property p_uvlo;
      (system_state_q == LLCF_RUN || system_state_q == LLCF_SOFT) && gate_supply_low |-> ##[1:2]
         system_state_q == LLCF_FAULT;
   endproperty
   property p_no_switch;
      $past(feedback_below_burst_cmp) |-> !switching_allowed_q;
   endproperty
   property p_short;
      system_state_q == LLCF_IDLE && $past(system_state_q) == LLCF_IDLE |-> sense_short_q;
   endproperty
   a_done: assert property (p_done) else $error("soft-start done wrong");
   a_charge: assert property (p_charge) else $error("charge enable wrong");
   a_burst_sel: assert property (p_burst_sel) else $error("burst threshold during soft start");
   a_ramp: assert property (p_ramp) else $error("ramp did not reverse");
   a_blank: assert property (p_blank) else $error("direction edge not blanked");
   a_mux: assert property (p_mux) else $error("average mux wrong");
   a_stops: assert property (p_stops) else $error("gate stop wrong");
   a_copies: assert property (p_copies) else $error("comparator copy wrong");
   a_uvlo: assert property (p_uvlo) else $error("no fault on low gate supply");
   a_no_switch: assert property (p_no_switch) else $error("switching with feedback low");
   a_short: assert property (p_short) else $error("sense not shorted in idle");
endmodule

bind llcf_ctrl llcf_ctrl_properties u_props (.*);

// File: testbench/llcf_stage_model.sv
/*
 Gate timing model standing in for the waveform generator and power stage.
 Assumes run comes from switching_allowed_q; gates stop mid-cycle when it drops.
*/
module llcf_stage_model (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Control and gates
   input wire logic run,
   output logic high_side_on,
   output logic low_side_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] phase_q;
   // Dead time of 20 cycles outlasts the blanking span, so unblanked edges show
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_q <= 7'h00;
         high_side_on <= 1'b0;
         low_side_on <= 1'b0;
      end else begin
         phase_q <= (!run || phase_q == 7'h4f) ? 7'h00 : phase_q + 7'h01;
         high_side_on <= run && phase_q < 7'h14;
         low_side_on <= run && phase_q >= 7'h28 && phase_q < 7'h3c;
      end
   end
endmodule

// File: testbench/llc_feedback_and_current_protect_tb_top.sv
/*
 Self-checking bench for llcf_ctrl with the gate timing model.
 Assumes shortened timer limits of 20, 10 and 30 cycles.
*/
module llc_feedback_and_current_protect_tb_top import llcf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, reset = 1'b1;
   logic start_request, gate_supply_low, softstart_enable, softstart_above_feedback, feedback_below_burst_cmp;
   logic capacitive_region, sense_above_upper, sense_below_lower, sense_above_common, current_direction_flag;
   logic high_average_cmp, low_average_cmp, peak_overcurrent_cmp = 1'b0, high_side_on, low_side_on;
   logic softstart_done_q, softstart_charge_enable_q, select_supply_q, select_burst_threshold_q, sense_short_q;
   logic ramp_up_q, average_mux_pass_q, switching_allowed_q, feedback_below_burst_flag_q, sense_above_upper_q;
   logic sense_below_lower_q, sense_above_common_q, high_side_stop_q, low_side_stop_q, current_direction_q;
   logic gate_supply_fault_q, peak_overcurrent_q, high_average_overcurrent_q, low_average_overcurrent_q;
   logic [4:0] system_state_q;
   logic hs_prev = 1'b0, pk_mode = 1'b0;
   logic [7:0] c;
   int miscompares = 0, n_tests = 0, nf = 0, last;
   int lim [4] = '{20, 10, 30, 0};
   llcf_ctrl #(.FB_LOW_LIMIT(20), .AVG_HIGH_LIMIT(10), .AVG_LOW_LIMIT(30)) u_dut (.*);
   llcf_stage_model u_stage (.clock(clock), .reset(reset), .run(switching_allowed_q),
      .high_side_on(high_side_on), .low_side_on(low_side_on));
   initial forever #12.5 clock = ~clock;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task tick;
      @(posedge clock);
      #1;
   endtask
   task check(logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task test_done;
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wait_state(logic [4:0] s);
      int k;
      k = 0;
      while (system_state_q !== s && k < 500) begin
         tick();
         k++;
      end
      check(system_state_q, s);
   endtask
   task bring_up;
      start_request = 1'b1;
      softstart_enable = 1'b1;
      softstart_above_feedback = 1'b1;
      wait_state(LLCF_RUN);
      repeat (2) tick();
      check(select_supply_q, 1'b1);
      check(select_burst_threshold_q, 1'b1);
   endtask
   // Only a fault leads back to idle, so a gate supply drop is used
   task go_idle;
      gate_supply_low = 1'b1;
      wait_state(LLCF_FAULT);
      gate_supply_low = 1'b0;
      start_request = 1'b0;
      softstart_enable = 1'b0;
      wait_state(LLCF_IDLE);
      tick();
      check(sense_short_q, 1'b1);
   endtask
   task set_cond(int w, logic v);
      case (w)
         0: feedback_below_burst_cmp = v;
         1: high_average_cmp = v;
         2: low_average_cmp = v;
         default: gate_supply_low = v;
      endcase
   endtask
   function automatic logic effect(int w);
      case (w)
         0: return system_state_q == LLCF_START;
         1: return high_average_overcurrent_q;
         2: return low_average_overcurrent_q;
         default: return system_state_q == LLCF_FAULT;
      endcase
   endfunction
   function automatic logic pat(int n);
      return n != 19;
   endfunction
   function automatic logic exp_peak(int n);
      int run;
      logic e;
      run = 0;
      e = 1'b0;
      for (int k = 16; k <= n; k++) begin
         run = pat(k) ? run + 1 : 0;
         if (run >= 4) e = 1'b1;
      end
      return e;
   endfunction
   always @(posedge clock) begin
      #1;
      if (system_state_q === LLCF_START) nf = 0;
      else if (hs_prev && !high_side_on) nf = nf + 1;
      hs_prev = high_side_on;
      peak_overcurrent_cmp = pk_mode && pat(nf + 1);
   end
   initial begin
      #1_000_000;
      miscompares++;
      test_done();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {start_request, gate_supply_low, softstart_enable, softstart_above_feedback, feedback_below_burst_cmp} = '0;
      {capacitive_region, sense_above_upper, sense_below_lower, sense_above_common, current_direction_flag} = '0;
      {high_average_cmp, low_average_cmp} = '0;
      void'($urandom(32'h2ed9));
      repeat (3) @(posedge clock);
      #1;
      check(system_state_q, LLCF_IDLE);
      check(sense_short_q, 1'b1);
      reset = 1'b0;
      tick();
      bring_up();
      repeat (400) begin
         tick();
         capacitive_region = ($urandom % 8) == 0;
         {softstart_above_feedback, sense_above_upper, sense_below_lower} = 3'($urandom);
         {sense_above_common, current_direction_flag} = 2'($urandom);
      end
      {capacitive_region, softstart_above_feedback} = 2'b01;
      go_idle();
      for (int w = 0; w < 4; w++) begin
         bring_up();
         if (lim[w] > 0) begin
            set_cond(w, 1'b1);
            repeat (lim[w] - 1) tick();
            set_cond(w, 1'b0);
            tick();
         end
         set_cond(w, 1'b1);
         c = 8'h00;
         while (!effect(w) && c < 8'd100) begin
            tick();
            c++;
         end
         check(c, (w == 3) ? 8'd1 : 8'(lim[w] + 1));
         if (w == 0) begin
            repeat (10) tick();
            check(system_state_q, LLCF_START);
            check(switching_allowed_q, 1'b0);
         end
         if (w == 3) check(gate_supply_fault_q, 1'b1);
         set_cond(w, 1'b0);
         go_idle();
      end
      pk_mode = 1'b1;
      bring_up();
      last = nf;
      repeat (3000) begin
         tick();
         #1;
         if (nf != last) begin
            last = nf;
            repeat (4) tick();
            check(peak_overcurrent_q, exp_peak(last));
         end
         if (last >= 23) break;
      end
      check(peak_overcurrent_q, 1'b1);
      pk_mode = 1'b0;
      go_idle();
      test_done();
   end
endmodule
